/* common/jsd_cfg.svh */
`ifndef JSD_CFG_SVH
`define JSD_CFG_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define JSD_CLK_HZ 50000000
`define JSD_GAP_MS 50
`define JSD_GAP_CYC ((`JSD_CLK_HZ / 1000) * `JSD_GAP_MS)
`define JSD_CNT_W 22

// ----------------------------------------
// job numbering and input map
// ----------------------------------------
`define JSD_JOB_W 5
`define JSD_JOB_ONE 5'h01
`define JSD_JOB_TWO 5'h02
`define JSD_JOB_NONE 5'h00
`define JSD_JOB_MAX 5'h1f
`define JSD_MODE_W 2
`define JSD_BIT_LEVEL 0
`define JSD_BIT_PULSE 0

`endif

/* common/jsd_pkg.sv */
`include "jsd_cfg.svh"

package jsd_pkg;

  typedef enum logic [1:0] {
    JSD_MODE_OFF = 2'h0,
    JSD_MODE_LEVEL = 2'h1,
    JSD_MODE_BINARY = 2'h2,
    JSD_MODE_PULSE = 2'h3
  } jsd_mode_t;

  // gray order along idle -> count -> switch -> confirm
  typedef enum logic [1:0] {
    JSD_ST_IDLE = 2'h0,
    JSD_ST_COUNT = 2'h1,
    JSD_ST_SWITCH = 2'h3,
    JSD_ST_CONFIRM = 2'h2
  } jsd_state_t;

  typedef struct packed {
    logic [`JSD_JOB_W-1:0] sync1;
    logic [`JSD_JOB_W-1:0] sync2;
    logic [`JSD_JOB_W-1:0] prev;
    jsd_state_t state;
    logic [`JSD_CNT_W-1:0] gapCnt;
    logic [`JSD_JOB_W-1:0] pulseCnt;
    logic [`JSD_JOB_W-1:0] activeJob;
    logic [`JSD_JOB_W-1:0] shownJob;
    logic switchReq;
    logic pending;
    logic ready;
    logic confirm;
  } jsd_reg_t;

  typedef struct packed {
    logic switchReq;
    logic [`JSD_JOB_W-1:0] job;
  } jsd_switch_t;

endpackage

/* hdl/jsd_job_select.sv */
// Function
// - in level mode the select input low runs job one and high runs job two.
// - in binary mode up to five select bits form a job number from 1 to 31.
// - in binary mode a switch starts as soon as the synchronised pattern changes.
// - the shown active job follows the running job only at the next trigger.
// - pulse selection is taken only while ready is high, and the controller starts none while it is low.
// - pulse mode counts pulses until a gap of 50 ms and then selects the job equal to the count.
// - pulse mode drops ready when the 50 ms gap after the last pulse is seen.
// - ready stays low until the switch to the chosen job is complete.
// - with confirm enabled a confirm pulse follows the switch before ready rises again.
`timescale 1ns/1ns

`include "jsd_cfg.svh"

module jsd_job_select
  import jsd_pkg::*;
#(
  // gap that ends a pulse sequence, in clock cycles
  // a bench may shorten it, the device keeps the default
  parameter int unsigned GAP_CYC = `JSD_GAP_CYC
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [`JSD_JOB_W-1:0] selIn,
  input wire jsd_mode_t mode,
  input wire logic confirmEn,
  input wire logic [`JSD_JOB_W-1:0] jobCount,
  input wire logic trigger,
  input wire logic switchDone,
  output jsd_switch_t switchOut,
  output logic [`JSD_JOB_W-1:0] activeJob,
  output logic [`JSD_JOB_W-1:0] shownJob,
  output logic ready,
  output logic confirm
);

  jsd_reg_t r;
  jsd_reg_t next_r;

  // ----------------------------------------
  // job validity
  // ----------------------------------------
  // job zero and jobs beyond the stored count are never taken
  function automatic logic jobOk(
    input logic [`JSD_JOB_W-1:0] j,
    input logic [`JSD_JOB_W-1:0] n
  );
    jobOk = (j != `JSD_JOB_NONE) && (j <= n);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic pulseBit;
    logic prevBit;
    logic [`JSD_JOB_W-1:0] want;
    next_r = r;
    pulseBit = r.sync2[`JSD_BIT_PULSE];
    prevBit = r.prev[`JSD_BIT_PULSE];
    want = r.activeJob;
    // ----------------------------------------
    // synchronisers and shown job
    // ----------------------------------------
    // only the second stage, and its delayed copy prev for edge detection, feeds any decoding
    next_r.sync1 = selIn;
    next_r.sync2 = r.sync1;
    next_r.prev = r.sync2;
    next_r.switchReq = 1'b0;
    next_r.confirm = 1'b0;
    if (trigger) begin
      next_r.shownJob = r.activeJob;
    end
    // ----------------------------------------
    // selection state machine
    // ----------------------------------------
    unique case (r.state)
      JSD_ST_IDLE: begin
        next_r.ready = 1'b1;
        unique case (mode)
          JSD_MODE_LEVEL: begin
            want = r.sync2[`JSD_BIT_LEVEL] ? `JSD_JOB_TWO : `JSD_JOB_ONE;
          end
          JSD_MODE_BINARY: begin
            want = r.sync2;
          end
          JSD_MODE_PULSE: begin
            // a rising edge with ready high opens a sequence
            if (r.ready && pulseBit && !prevBit) begin
              next_r.state = JSD_ST_COUNT;
              next_r.pulseCnt = 5'h01;
              next_r.gapCnt = '0;
            end
          end
          default: begin
            want = r.activeJob;
          end
        endcase
        // level and binary switch at once on a change, no handshake
        if (mode != JSD_MODE_PULSE && want != r.activeJob && jobOk(want, jobCount)) begin
          next_r.activeJob = want;
          next_r.switchReq = 1'b1;
        end
      end
      JSD_ST_COUNT: begin
        if (pulseBit && !prevBit) begin
          // saturate so a long burst cannot wrap into a small job
          if (r.pulseCnt != `JSD_JOB_MAX) begin
            next_r.pulseCnt = r.pulseCnt + 5'h01;
          end
          next_r.gapCnt = '0;
        end else if (pulseBit) begin
          next_r.gapCnt = '0;
        end else if (r.gapCnt >= `JSD_CNT_W'(GAP_CYC - 1)) begin
          next_r.ready = 1'b0;
          if (jobOk(r.pulseCnt, jobCount)) begin
            next_r.activeJob = r.pulseCnt;
            next_r.switchReq = 1'b1;
            next_r.pending = 1'b1;
            next_r.state = JSD_ST_SWITCH;
          end else begin
            next_r.state = JSD_ST_SWITCH;
            next_r.pending = 1'b0;
          end
        end else begin
          next_r.gapCnt = r.gapCnt + `JSD_CNT_W'(1);
        end
      end
      JSD_ST_SWITCH: begin
        next_r.ready = 1'b0;
        if (!r.pending || switchDone) begin
          next_r.pending = 1'b0;
          if (confirmEn && r.pending) begin
            next_r.confirm = 1'b1;
            next_r.state = JSD_ST_CONFIRM;
          end else begin
            next_r.state = JSD_ST_IDLE;
          end
        end
      end
      JSD_ST_CONFIRM: begin
        // ready rises one cycle after the confirm pulse
        next_r.ready = 1'b1;
        next_r.state = JSD_ST_IDLE;
      end
    endcase
    // ----------------------------------------
    // leaving pulse mode
    // ----------------------------------------
    // a partial count is dropped; a started switch still runs to its end
    if (mode != JSD_MODE_PULSE && r.state != JSD_ST_SWITCH && r.state != JSD_ST_CONFIRM) begin
      next_r.state = (r.state == JSD_ST_COUNT) ? JSD_ST_IDLE : next_r.state;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // ready stays low until the first edge after release
      r <= '{
        sync1: '0,
        sync2: '0,
        prev: '0,
        state: JSD_ST_IDLE,
        gapCnt: '0,
        pulseCnt: '0,
        activeJob: `JSD_JOB_ONE,
        shownJob: `JSD_JOB_ONE,
        switchReq: 1'b0,
        pending: 1'b0,
        ready: 1'b0,
        confirm: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // all straight from the state register, no glitches toward the loader
  assign switchOut = '{switchReq: r.switchReq, job: r.activeJob};
  assign activeJob = r.activeJob;
  assign shownJob = r.shownJob;
  assign ready = r.ready;
  assign confirm = r.confirm;

endmodule

/* test/jsd_chk.sv */
`timescale 1ns/1ns
module jsd_chk
  import jsd_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] selIn,
  input wire jsd_mode_t mode,
  input wire logic confirmEn,
  input wire logic [4:0] jobCount,
  input wire logic trigger,
  input wire logic switchDone,
  input wire jsd_switch_t switchOut,
  input wire logic [4:0] activeJob,
  input wire logic [4:0] shownJob,
  input wire logic ready,
  input wire logic confirm
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----
  // properties
  // ----
  AST_LVL: assert property ((mode == JSD_MODE_LEVEL && $stable(selIn) && $past(arst_n, 5))[*4]
    |-> activeJob == (selIn[0] ? 5'h02 : 5'h01)) else $error("level job wrong");
  AST_BIN: assert property ((mode == JSD_MODE_BINARY && $stable(selIn) && $stable(jobCount))[*4]
    |-> selIn == 5'h00 || selIn > jobCount || activeJob == selIn) else $error("binary job wrong");
  AST_REQ: assert property (mode == JSD_MODE_BINARY && switchOut.switchReq
    |-> $past(selIn, 3) != $past(selIn, 4)) else $error("switch not 3 edges after change");
  AST_BAD: assert property ($changed(activeJob) || switchOut.switchReq |-> switchOut.switchReq
    && switchOut.job != 5'h00 && switchOut.job <= jobCount) else $error("bad job taken");
  AST_SHOW: assert property (1'b1 |=> shownJob == ($past(trigger) ? $past(activeJob) : $past(shownJob)))
    else $error("shown job wrong");
  AST_CONF: assert property (confirm |=> ready && !confirm) else $error("ready not after confirm");
  AST_CEN: assert property (confirm |-> confirmEn && !ready) else $error("confirm unexpected");
  AST_PRDY: assert property (mode == JSD_MODE_PULSE && ready && selIn[0] |=> ready)
    else $error("ready fell in pulse");
endmodule
bind jsd_job_select jsd_chk chk (.mclk, .arst_n, .selIn, .mode, .confirmEn, .jobCount, .trigger,
  .switchDone, .switchOut, .activeJob, .shownJob, .ready, .confirm);

/* test/jsd_loader_model.sv */
`timescale 1ns/1ns
module jsd_loader_model
  import jsd_pkg::*;
(
  input wire logic mclk,
  input wire jsd_switch_t switchOut,
  output logic switchDone = 1'b0
);
  int n = 0;
  // ----
  // loading takes some cycles; done is one pulse
  // ----
  always @(posedge mclk) begin
    switchDone <= 1'b0;
    if (switchOut.switchReq) n <= 4;
    else if (n > 0) begin
      n <= n - 1;
      switchDone <= (n == 1);
    end
  end
endmodule

/* test/test_jsd_job_select.sv */
`timescale 1ns/1ns
`include "jsd_cfg.svh"
module test_jsd_job_select;
  import jsd_pkg::*;
  // short gap so pulse sequences finish within the run
  localparam int simGap = 64;
  logic mclk = 0, arst_n = 0, confirmEn = 0, trigger = 0, switchDone, ready, confirm;
  logic [4:0] selIn = 5'h00, jobCount = 5'h1f, activeJob, shownJob;
  logic [4:0] tbl [4] = '{5'h03, 5'h1f, 5'h10, 5'h01};
  jsd_mode_t mode = JSD_MODE_OFF;
  jsd_switch_t switchOut;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  jsd_job_select #(.GAP_CYC(simGap)) uut (.mclk, .arst_n, .selIn, .mode, .confirmEn, .jobCount, .trigger,
    .switchDone, .switchOut, .activeJob, .shownJob, .ready, .confirm);
  jsd_loader_model lm (.mclk, .switchOut, .switchDone);
  initial forever #10 mclk = ~mclk;
  // ----
  // tasks
  // ----
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic chk(logic [4:0] got, logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse_job(int k, logic [4:0] exp, logic conf, logic take);
    confirmEn = conf;
    repeat (k) begin
      selIn = 5'h01;
      tick(5);
      selIn = 5'h00;
      tick(5);
    end
    tick(simGap - 4);
    chk(ready, 1);
    tick(1);
    chk(ready, 0);
    chk(switchOut.switchReq, take);
    chk(activeJob, exp);
    if (take) begin
      tick(5);
      chk(ready, 0);
      tick(1);
      chk(confirm, conf);
      chk(ready, 0);
      tick(1);
    end else begin
      tick(2);
    end
    chk(ready, 1);
    chk(confirm, 0);
  endtask
  task automatic test_done();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    tick(10);
    arst_n = 1;
    tick(1);
    chk(ready, 1);
    mode = JSD_MODE_LEVEL;
    tick(4);
    chk(activeJob, 1);
    selIn = 5'h01;
    tick(2);
    chk(activeJob, 1);
    tick(1);
    chk(activeJob, 2);
    chk(shownJob, 1);
    trigger = 1;
    tick(1);
    trigger = 0;
    chk(shownJob, 2);
    selIn = 5'h00;
    tick(4);
    chk(activeJob, 1);
    mode = JSD_MODE_BINARY;
    foreach (tbl[i]) begin
      selIn = tbl[i];
      tick(3);
      chk(switchOut.switchReq, 1);
      chk(activeJob, tbl[i]);
      tick(1);
      chk(switchOut.switchReq, 0);
    end
    jobCount = 5'h06;
    selIn = 5'h07;
    tick(4);
    chk(activeJob, 1);
    selIn = 5'h00;
    tick(4);
    chk(activeJob, 1);
    selIn = 5'h06;
    tick(4);
    chk(activeJob, 6);
    selIn = 5'h00;
    mode = JSD_MODE_PULSE;
    tick(4);
    chk(ready, 1);
    pulse_job(3, 5'h03, 1'b1, 1'b1);
    trigger = 1;
    tick(1);
    trigger = 0;
    chk(shownJob, 3);
    pulse_job(2, 5'h02, 1'b0, 1'b1);
    pulse_job(7, 5'h02, 1'b0, 1'b0);
    test_done();
  end
endmodule
